// ===== logic/nvs_slave.sv
`timescale 1ns/100ps
module nvs_slave import nvs_pkg::*; #(
    // arbitrary device type code
    parameter logic [3:0] TYPE_CODE = 4'h5
) (
    // system clock and power-on reset
    input wire logic mclk,
    input wire logic nrst,
    // serial link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // straps
    input wire logic [1:0] device_select_straps,
    input wire logic wp
);
    // link side: sample on the serial clock rising edge
    logic link_bit;
    logic link_tgl;

    always_ff @(posedge scl or negedge nrst) begin
        if (!nrst) begin
            link_bit <= 1'b0;
            link_tgl <= 1'b0;
        end else begin
            link_bit <= sda_in;
            link_tgl <= ~link_tgl;
        end
    end

    // crossings into mclk
    logic scl_s;
    logic sda_s;
    logic tgl_s;
    logic bit_s;
    logic [1:0] sel_s;
    logic wp_s;

    nvs_sync #(.W(7)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d({scl, sda_in, link_tgl, link_bit, device_select_straps, wp}),
        .q({scl_s, sda_s, tgl_s, bit_s, sel_s, wp_s})
    );

    logic scl_d;
    logic sda_d;
    logic tgl_d;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            scl_d <= 1'b0;
            sda_d <= 1'b1;
            tgl_d <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            tgl_d <= tgl_s;
        end
    end

    wire rise_ev = tgl_s ^ tgl_d;
    wire fall_ev = scl_d && !scl_s;
    wire start_ev = scl_s && scl_d && sda_d && !sda_s;
    wire stop_ev = scl_s && scl_d && !sda_d && sda_s;

    // engine state
    nvs_state_t state;
    nvs_state_t nxt;
    logic [2:0] cnt;
    logic [6:0] shreg;
    logic [7:0] tx;
    logic [8:0] addr;
    logic page;
    logic ack_ok;

    // array and write buffer
    logic [7:0] mem_q [NVS_DEPTH];
    logic [7:0] rd_q;
    logic buf_ready;
    logic drain_valid;
    logic [NVS_BUF_W-1:0] drain_data;

    wire [7:0] rx_byte = {shreg, bit_s};
    wire byte_done = rise_ev && cnt == NVS_LAST_BIT;
    wire type_ok = rx_byte[NVS_TYPE_HI:NVS_TYPE_LO] == TYPE_CODE;
    wire sel_ok = rx_byte[NVS_SEL_HI:NVS_SEL_LO] == sel_s;
    wire dev_ok = type_ok && sel_ok;
    wire can_write = !wp_s && buf_ready;
    wire push = state == NVS_WDATA && byte_done && can_write;
    wire rd_busy = (state == NVS_ACK && nxt == NVS_RDATA) || state == NVS_MACK;
    wire drain_ready = !rd_busy;
    wire drain = drain_valid && drain_ready;
    wire [8:0] drain_addr = drain_data[NVS_BUF_W-1:NVS_DW];
    wire [8:0] word_addr = {page, rx_byte};

    assign sda_out = 1'b0;

    nvs_fifo2 #(.W(NVS_BUF_W)) u_buf (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data({addr, rx_byte}),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    // single-port array: write from buffer, else read at addr
    always_ff @(posedge mclk) begin
        if (drain) begin
            mem_q[drain_addr] <= drain_data[NVS_DW-1:0];
        end else begin
            rd_q <= mem_q[addr];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= NVS_IDLE;
            nxt <= NVS_IDLE;
            cnt <= 3'h0;
            shreg <= 7'h00;
            tx <= 8'h00;
            addr <= NVS_ADDR_RST;
            page <= 1'b0;
            ack_ok <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_ev) begin
            state <= NVS_DEV;
            cnt <= 3'h0;
            ack_ok <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_ev) begin
            state <= NVS_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (state)
                NVS_IDLE: begin
                    sda_oe <= 1'b0;
                end
                NVS_DEV, NVS_WORD, NVS_WDATA: begin
                    if (rise_ev) begin
                        shreg <= rx_byte[6:0];
                        cnt <= cnt + 3'h1;
                    end
                    if (byte_done) begin
                        state <= NVS_ACK;
                        if (state == NVS_DEV) begin
                            if (!dev_ok) begin
                                state <= NVS_IDLE;
                            end
                            page <= rx_byte[NVS_PAGE_POS];
                            nxt <= rx_byte[NVS_RW_POS] ? NVS_RDATA : NVS_WORD;
                            if (rx_byte[NVS_RW_POS] && dev_ok) begin
                                addr <= {rx_byte[NVS_PAGE_POS], addr[7:0]};
                            end
                        end else if (state == NVS_WORD) begin
                            addr <= word_addr;
                            nxt <= NVS_WDATA;
                        end else if (can_write) begin
                            addr <= nvs_next_addr(addr);
                            nxt <= NVS_WDATA;
                        end else begin
                            state <= NVS_IDLE;
                        end
                    end
                end
                NVS_ACK: begin
                    if (fall_ev) begin
                        if (!sda_oe) begin
                            sda_oe <= 1'b1;
                        end else begin
                            state <= nxt;
                            cnt <= 3'h0;
                            sda_oe <= nxt == NVS_RDATA && !rd_q[7];
                            tx <= {rd_q[6:0], 1'b0};
                        end
                    end
                end
                NVS_RDATA: begin
                    if (fall_ev) begin
                        sda_oe <= !tx[7];
                        tx <= {tx[6:0], 1'b0};
                    end
                    if (rise_ev) begin
                        cnt <= cnt + 3'h1;
                        if (cnt == NVS_LAST_BIT) begin
                            state <= NVS_MACK;
                            addr <= nvs_next_addr(addr);
                        end
                    end
                end
                NVS_MACK: begin
                    if (rise_ev) begin
                        if (bit_s) begin
                            state <= NVS_IDLE;
                        end else begin
                            ack_ok <= 1'b1;
                        end
                    end
                    if (fall_ev) begin
                        if (ack_ok) begin
                            ack_ok <= 1'b0;
                            state <= NVS_RDATA;
                            cnt <= 3'h0;
                            sda_oe <= !rd_q[7];
                            tx <= {rd_q[6:0], 1'b0};
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_byte_in;
        rise_ev && cnt == NVS_LAST_BIT;
    endsequence

    sequence s_dev_byte;
        state == NVS_DEV ##0 s_byte_in;
    endsequence

    sequence s_read_byte;
        state == NVS_RDATA ##0 s_byte_in;
    endsequence

    oe_after_fall_a: assert property (
        $changed(sda_oe) |-> $past(fall_ev) || $past(start_ev) || $past(stop_ev))
        else $error("data line enable changed without a clock fall");

    sel_mismatch_a: assert property (
        s_dev_byte ##0 !sel_ok |=> state == NVS_IDLE)
        else $error("device answered with wrong select bits");

    wp_block_a: assert property (
        wp_s && $past(wp_s) && $past(wp_s, 2) |-> !drain)
        else $error("byte stored while write protected");

    wp_noinc_a: assert property (
        state == NVS_WDATA ##0 s_byte_in ##0 wp_s |=> state == NVS_IDLE && $stable(addr))
        else $error("protected write was acknowledged or stepped");

    addr_step_a: assert property (
        push |=> addr == nvs_next_addr($past(addr)))
        else $error("address did not step after a write byte");

    commit_time_a: assert property (
        push |-> ##[1:3] drain)
        else $error("written byte not committed in time");

    word_addr_a: assert property (
        state == NVS_WORD ##0 s_byte_in |=> addr == {page, $past(rx_byte)})
        else $error("byte address not formed from page and word");

    read_page_a: assert property (
        s_dev_byte ##0 dev_ok && rx_byte[0] |=> addr[8] == $past(rx_byte[1])
            && addr[7:0] == $past(addr[7:0]))
        else $error("read did not take page from address byte");

    ack_drive_a: assert property (
        state == NVS_ACK && fall_ev && !sda_oe |=> sda_oe [*2])
        else $error("acknowledge not driven after clock fall");

    rd_step_a: assert property (
        s_read_byte |=> addr == nvs_next_addr($past(addr)))
        else $error("address did not step after a read byte");

    first_bit_a: assert property (
        state == NVS_ACK && fall_ev && sda_oe && nxt == NVS_RDATA
            |=> sda_oe == !$past(rd_q[7]))
        else $error("first read bit not taken from the array");

    unsel_quiet_a: assert property (
        state == NVS_IDLE |=> !sda_oe)
        else $error("data line pulled while not addressed");

endmodule : nvs_slave

// ===== logic/nvs_pkg.sv
package nvs_pkg;

    // array shape
    localparam int unsigned NVS_DEPTH = 512;
    localparam int unsigned NVS_AW = 9;
    localparam int unsigned NVS_DW = 8;
    localparam int unsigned NVS_BUF_W = NVS_AW + NVS_DW;

    // slave address byte fields
    localparam int unsigned NVS_RW_POS = 0;
    localparam int unsigned NVS_PAGE_POS = 1;
    localparam int unsigned NVS_SEL_LO = 2;
    localparam int unsigned NVS_SEL_HI = 3;
    localparam int unsigned NVS_TYPE_LO = 4;
    localparam int unsigned NVS_TYPE_HI = 7;

    // reset values and counts
    localparam logic [8:0] NVS_ADDR_RST = 9'h000;
    localparam logic [2:0] NVS_LAST_BIT = 3'h7;
    localparam logic [1:0] NVS_BUF_SLOTS = 2'h2;

    // serial clock limit against the system clock
    localparam int unsigned NVS_MCLK_KHZ = 100000;
    localparam int unsigned NVS_SCL_MAX_KHZ = 1000;
    localparam int unsigned NVS_HALF_CYC = NVS_MCLK_KHZ / NVS_SCL_MAX_KHZ / 2;

    typedef enum logic [6:0] {
        NVS_IDLE = 7'h01,
        NVS_DEV = 7'h02,
        NVS_WORD = 7'h04,
        NVS_WDATA = 7'h08,
        NVS_RDATA = 7'h10,
        NVS_ACK = 7'h20,
        NVS_MACK = 7'h40
    } nvs_state_t;

    function automatic logic [8:0] nvs_next_addr(input logic [8:0] a);
        nvs_next_addr = a + 9'h001;
    endfunction : nvs_next_addr

endpackage : nvs_pkg

// ===== logic/nvs_sync.sv
`timescale 1ns/100ps
module nvs_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : nvs_sync

// ===== logic/nvs_fifo2.sv
`timescale 1ns/100ps
module nvs_fifo2 import nvs_pkg::*; #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] slot [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] used;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = used != NVS_BUF_SLOTS;
    assign out_valid = used != 2'h0;
    assign out_data = slot[rd_ptr];

    always_ff @(posedge mclk) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            used <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            used <= used + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : nvs_fifo2

// ===== bench/nvs_master.sv
`timescale 1ns/100ps
module nvs_master (
    // link clock
    input wire logic lclk,
    // serial link
    input wire logic sda_oe,
    output logic scl,
    output logic sda_in
);
    logic moe = 1'b0;

    initial scl = 1'b1;

    // wired-AND with pull-up: a released wire reads high
    assign sda_in = !(sda_oe | moe);

    // 504 ns high and 504 ns low per bit keep the serial clock under 1 MHz
    task automatic half();
        repeat (42) @(posedge lclk);
    endtask : half

    task automatic quarter();
        repeat (21) @(posedge lclk);
    endtask : quarter

    task automatic bit_io(input logic b, output logic s);
        moe <= !b;
        quarter();
        scl <= 1'b1;
        half();
        s = sda_in;
        scl <= 1'b0;
        quarter();
    endtask : bit_io

    task automatic start();
        moe <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        moe <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask : start

    task automatic stop();
        moe <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        moe <= 1'b0;
        half();
    endtask : stop

    // eight bits msb first, then the acknowledge slot in bit 0
    task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
    endtask : xbyte
endmodule : nvs_master

// ===== bench/nvs_slave_bench.sv
`timescale 1ns/100ps
module nvs_slave_bench import nvs_pkg::*;;
    localparam logic [3:0] TC = 4'h5;
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    // starts high so that the reset below is a falling edge for the link flops
    logic nrst = 1'b1;
    logic wp = 1'b0;
    logic [1:0] straps = 2'h0;
    logic scl, sda_in, sda_out, sda_oe;
    logic [7:0] mem [NVS_DEPTH];
    logic [8:0] ptr, q;
    int fail_count = 0;
    int checks_done = 0;

    initial forever #5 mclk = !mclk;
    initial forever #6 lclk = !lclk;

    nvs_slave #(.TYPE_CODE(TC)) u_nvs_slave (.mclk(mclk), .nrst(nrst), .scl(scl),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .device_select_straps(straps), .wp(wp));
    nvs_master u_nvs_master (.lclk(lclk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    function automatic logic [7:0] sadr(logic [1:0] s, logic p, logic r);
        return {TC, s, p, r};
    endfunction : sadr

    task automatic wr(input logic [1:0] s, input logic [8:0] a, input int n);
        logic [7:0] d;
        u_nvs_master.start();
        u_nvs_master.xbyte({sadr(s, a[8], 1'b0), 1'b1}, q);
        check({7'h0, q[0]}, 8'h00);
        u_nvs_master.xbyte({a[7:0], 1'b1}, q);
        check({7'h0, q[0]}, 8'h00);
        ptr = a;
        repeat (n) begin
            d = 8'($urandom);
            u_nvs_master.xbyte({d, 1'b1}, q);
            check({7'h0, q[0]}, {7'h0, wp});
            if (!wp) begin
                mem[ptr] = d;
                ptr = ptr + 9'h001;
            end
        end
        u_nvs_master.stop();
    endtask : wr

    task automatic rd(input logic [1:0] s, input logic p, input int n);
        u_nvs_master.start();
        u_nvs_master.xbyte({sadr(s, p, 1'b1), 1'b1}, q);
        check({7'h0, q[0]}, 8'h00);
        ptr = {p, ptr[7:0]};
        for (int i = n; i > 0; i--) begin
            u_nvs_master.xbyte({8'hFF, i == 1}, q);
            check(q[8:1], mem[ptr]);
            ptr = ptr + 9'h001;
        end
        u_nvs_master.stop();
    endtask : rd

    task automatic miss(input logic [7:0] b);
        u_nvs_master.start();
        u_nvs_master.xbyte({b, 1'b1}, q);
        check({7'h0, q[0]}, 8'h01);
        u_nvs_master.stop();
    endtask : miss

    // the run needs about 850 us at a 1 us serial bit; allow a little over a tenth more
    initial begin
        #950000;
        fail_count++;
        give_verdict();
    end

    initial begin
        logic [8:0] a;
        void'($urandom(32'h11443d07));
        nrst <= 1'b0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk) straps <= 2'(s);
            a = 9'($urandom);
            repeat (4) @(posedge mclk);
            wr(2'(s), a, 3);
            wr(2'(s), a, 0);
            rd(2'(s), a[8], 3);
            for (int j = 1; j < 4; j++) begin
                miss(sadr(2'(s) ^ 2'(j), a[8], 1'b0));
            end
            miss({~TC, 2'(s), 2'h0});
        end
        // last byte of the array rolls over to the first
        wr(straps, 9'h1FE, 3);
        wr(straps, 9'h1FE, 0);
        rd(straps, 1'b1, 3);
        // protected write leaves data alone and does not step the address latch past the word address
        @(posedge mclk) wp <= 1'b1;
        wr(straps, 9'h1FE, 2);
        @(posedge mclk) wp <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(straps, 1'b1, 2);
        // reset in mid-run brings the address latch back to zero
        @(posedge mclk) nrst <= 1'b0;
        repeat (12) @(posedge mclk);
        check({7'h0, sda_oe}, 8'h00);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        ptr = 9'h000;
        rd(straps, 1'b0, 1);
        check({7'h0, sda_out}, 8'h00);
        give_verdict();
    end
endmodule : nvs_slave_bench
